// File: rtl/uvd_pkg.sv
package uvd_pkg;
   localparam int APB_AW = 12;
   localparam int APB_DW = 32;
   // Printed offsets are register indices; byte address is four times the index
   localparam logic [9:0] IDX_DET_CTRL = 10'h0E4;
   localparam logic [9:0] IDX_AUX_TWO = 10'h0F7;
   localparam logic [9:0] IDX_INT_STAT = 10'h100;
   localparam logic [9:0] IDX_INT_MASK = 10'h101;
   localparam logic [11:0] ADDR_DET_CTRL = {IDX_DET_CTRL, 2'b00};
   localparam logic [11:0] ADDR_AUX_TWO = {IDX_AUX_TWO, 2'b00};
   localparam logic [11:0] ADDR_INT_STAT = {IDX_INT_STAT, 2'b00};
   localparam logic [11:0] ADDR_INT_MASK = {IDX_INT_MASK, 2'b00};
   localparam int SEL_W = 4;
   localparam int SEL_LSB = 0;
   localparam int FLAG_BIT = 4;
   localparam int SLEEP_POWER_SAVING_BIT = 5;
   localparam int EVT_LOW_BIT = 0;
   localparam logic [3:0] SEL_OFF = 4'h0;
   localparam logic [3:0] SEL_RST = 4'h0;
   localparam logic FLAG_RST = 1'b0;
   localparam logic [7:0] AUX_TWO_RST = 8'h06;
   localparam logic [0:0] INT_RST = 1'b0;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [2:0] {
      UVD_FAST = 3'b000,
      UVD_SLOW = 3'b001,
      UVD_IDLE = 3'b010,
      UVD_HALT = 3'b011,
      UVD_STOP = 3'b100
   } uvd_mode_t;

   typedef struct packed {
      logic flag;
      logic [SEL_W-1:0] sel;
   } uvd_ctrl_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [APB_DW-1:0] prdata;
   } uvd_apb_rsp_t;
endpackage : uvd_pkg

// File: rtl/uvd_sync.sv
`timescale 1ns/1ps
module uvd_sync import uvd_pkg::*; #(
   parameter int W = 1
) (
   input wire logic clk_sys, // System clock
   input wire logic rst_n, // Synchronised reset, active low
   input wire logic [W-1:0] d, // Asynchronous level
   output logic [W-1:0] q // Synchronised level
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // First stage feeds only the second
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule : uvd_sync

// File: rtl/uvd_ctrl.sv
// Summary of operation
// - Bits 3 to 0 of the detector control register select the threshold, and code 0000 keeps the detector off.
// - Each nonzero code enables the detector at one of fifteen rising thresholds and is passed to the comparator.
// - Bit 4 of the detector control register is the low-supply flag, which software clears by writing zero.
// - Bit 5 of the auxiliary register, when set in Idle, Halt or Stop, forces the detector off.
// - In Fast or Slow, or in a sleep mode with the saving bit clear, the detector follows the code alone.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module uvd_ctrl import uvd_pkg::*; (
   input wire logic clk_sys, // System clock, 100 MHz
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction, 1 = write
   input wire logic [APB_AW-1:0] paddr, // APB byte address
   input wire logic [APB_DW-1:0] pwdata, // APB write data
   output logic [APB_DW-1:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire uvd_mode_t op_mode, // Chip operating mode
   input wire logic cmp_below, // Comparator: supply below threshold
   output logic det_enable, // Comparator enable
   output logic [SEL_W-1:0] threshold_select, // Threshold code to comparator
   output logic irq // Level interrupt
);
   logic [1:0] rst_pipe_r;
   logic rst_n;
   logic cmp_below_s;

   // Reset released through two flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_pipe_r <= 2'b00;
      end else begin
         rst_pipe_r <= {rst_pipe_r[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_r[1];

   // Comparator output is analogue and asynchronous
   uvd_sync #(.W(1)) u_cmp_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .d(cmp_below),
      .q(cmp_below_s)
   );

   uvd_ctrl_t ctrl_r, ctrl_nxt;
   logic [7:0] aux_r, aux_nxt;
   logic [0:0] ist_r, ist_nxt;
   logic [0:0] imask_r, imask_nxt;
   logic det_en_r, det_en_nxt;
   logic [SEL_W-1:0] thr_r, thr_nxt;
   logic irq_r, irq_nxt;
   uvd_apb_rsp_t rsp_r, rsp_nxt;

   logic acc_start;
   logic acc_done;
   logic wr_done;
   logic sleeping;
   logic mapped;
   logic low_event;

   assign acc_start = psel && penable && !rsp_r.pready;
   assign acc_done = psel && penable && rsp_r.pready;
   assign wr_done = acc_done && pwrite && !rsp_r.pslverr;
   assign sleeping = (op_mode == UVD_IDLE) || (op_mode == UVD_HALT) || (op_mode == UVD_STOP);
   assign mapped = (paddr == ADDR_DET_CTRL) || (paddr == ADDR_AUX_TWO) ||
                   (paddr == ADDR_INT_STAT) || (paddr == ADDR_INT_MASK);
   // Gated by enable: comparator output is meaningless while it is powered down
   assign low_event = det_en_r && cmp_below_s;

   // APB slave: one wait state, answer on the second access edge
   always_comb begin
      rsp_nxt = rsp_r;
      rsp_nxt.pready = acc_start;
      if (acc_start) begin
         rsp_nxt.pslverr = !mapped;
         rsp_nxt.prdata = '0;
         if (!pwrite) begin
            case (paddr)
               ADDR_DET_CTRL: rsp_nxt.prdata[4:0] = {ctrl_r.flag, ctrl_r.sel};
               ADDR_AUX_TWO: rsp_nxt.prdata[7:0] = aux_r;
               ADDR_INT_STAT: rsp_nxt.prdata[0] = ist_r[0];
               ADDR_INT_MASK: rsp_nxt.prdata[0] = imask_r[0];
               default: rsp_nxt.prdata = '0;
            endcase
         end
      end else begin
         rsp_nxt.pslverr = 1'b0;
      end
   end

   // Register file
   always_comb begin
      ctrl_nxt = ctrl_r;
      aux_nxt = aux_r;
      ist_nxt = ist_r;
      imask_nxt = imask_r;
      if (wr_done) begin
         case (paddr)
            ADDR_DET_CTRL: begin
               ctrl_nxt.sel = pwdata[SEL_LSB +: SEL_W];
               // Writing one leaves the flag alone
               if (!pwdata[FLAG_BIT]) begin
                  ctrl_nxt.flag = 1'b0;
               end
            end
            ADDR_AUX_TWO: aux_nxt = pwdata[7:0];
            ADDR_INT_STAT: ist_nxt = ist_r & ~pwdata[EVT_LOW_BIT +: 1];
            ADDR_INT_MASK: imask_nxt = pwdata[EVT_LOW_BIT +: 1];
            default: ;
         endcase
      end
      // Hardware set wins over a clear in the same cycle
      if (low_event) begin
         ctrl_nxt.flag = 1'b1;
         ist_nxt[0] = 1'b1;
      end
   end

   // Detector enable and threshold toward the comparator
   always_comb begin
      det_en_nxt = 1'b0;
      thr_nxt = SEL_OFF;
      if (ctrl_r.sel == SEL_OFF) begin
         det_en_nxt = 1'b0;
      end else if (sleeping && aux_r[SLEEP_POWER_SAVING_BIT]) begin
         det_en_nxt = 1'b0;
      end else begin
         det_en_nxt = 1'b1;
         thr_nxt = ctrl_r.sel;
      end
      irq_nxt = |(ist_nxt & imask_nxt);
   end

   // Bus answer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rsp_r <= '0;
      end else begin
         rsp_r <= rsp_nxt;
      end
   end

   // Software-visible registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= '{flag: FLAG_RST, sel: SEL_RST};
         aux_r <= AUX_TWO_RST;
         ist_r <= INT_RST;
         imask_r <= INT_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
         aux_r <= aux_nxt;
         ist_r <= ist_nxt;
         imask_r <= imask_nxt;
      end
   end

   // Comparator drive and interrupt line
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         det_en_r <= 1'b0;
         thr_r <= SEL_OFF;
         irq_r <= 1'b0;
      end else begin
         det_en_r <= det_en_nxt;
         thr_r <= thr_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign prdata = rsp_r.prdata;
   assign pready = rsp_r.pready;
   assign pslverr = rsp_r.pslverr;
   assign det_enable = det_en_r;
   assign threshold_select = thr_r;
   assign irq = irq_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_zero_code_off;
      (ctrl_r.sel == SEL_OFF) |=> !det_enable;
   endproperty
   a_zero_code_off: assert property (p_zero_code_off) else $error("detector on with zero code");

   property p_code_passed;
      (ctrl_r.sel != SEL_OFF) && !(sleeping && aux_r[SLEEP_POWER_SAVING_BIT]) |=> threshold_select == $past(ctrl_r.sel);
   endproperty
   a_code_passed: assert property (p_code_passed) else $error("threshold code not passed on");

   property p_on_has_code;
      det_enable |-> (threshold_select != SEL_OFF);
   endproperty
   a_on_has_code: assert property (p_on_has_code) else $error("detector on with no threshold");

   property p_flag_clear;
      wr_done && (paddr == ADDR_DET_CTRL) && !pwdata[FLAG_BIT] && !low_event |=> !ctrl_r.flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by zero write");

   property p_flag_kept;
      ctrl_r.flag && !(wr_done && (paddr == ADDR_DET_CTRL)) |=> ctrl_r.flag;
   endproperty
   a_flag_kept: assert property (p_flag_kept) else $error("flag lost without a write");

   property p_saving_off;
      sleeping && aux_r[SLEEP_POWER_SAVING_BIT] |=> !det_enable;
   endproperty
   a_saving_off: assert property (p_saving_off) else $error("detector on while saving in sleep");

   property p_follow_code;
      (!sleeping || !aux_r[SLEEP_POWER_SAVING_BIT]) && (ctrl_r.sel != SEL_OFF) |=> det_enable;
   endproperty
   a_follow_code: assert property (p_follow_code) else $error("detector off despite code");

   property p_low_sets_flag;
      det_en_r && cmp_below_s |=> ctrl_r.flag ##1 (irq || !imask_r[0]);
   endproperty
   a_low_sets_flag: assert property (p_low_sets_flag) else $error("low supply did not set flag");

   property p_apb_wait;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");

   property p_off_no_code;
      !det_enable |-> (threshold_select == SEL_OFF);
   endproperty
   a_off_no_code: assert property (p_off_no_code) else $error("threshold shown while detector off");

   property p_sel_write;
      wr_done && (paddr == ADDR_DET_CTRL) |=> ctrl_r.sel == $past(pwdata[SEL_LSB +: SEL_W]);
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("threshold code not stored");

   property p_flag_one_write;
      ctrl_r.flag && wr_done && (paddr == ADDR_DET_CTRL) && pwdata[FLAG_BIT] |=> ctrl_r.flag;
   endproperty
   a_flag_one_write: assert property (p_flag_one_write) else $error("flag cleared by writing one");

   property p_read_det;
      acc_start && !pwrite && (paddr == ADDR_DET_CTRL) |=> prdata == {27'h0, $past(ctrl_r.flag), $past(ctrl_r.sel)};
   endproperty
   a_read_det: assert property (p_read_det) else $error("detector control read wrong");

   property p_aux_write;
      wr_done && (paddr == ADDR_AUX_TWO) |=> aux_r == $past(pwdata[7:0]);
   endproperty
   a_aux_write: assert property (p_aux_write) else $error("auxiliary register not stored");

   property p_read_aux;
      acc_start && !pwrite && (paddr == ADDR_AUX_TWO) |=> prdata == {24'h0, $past(aux_r)};
   endproperty
   a_read_aux: assert property (p_read_aux) else $error("auxiliary register read wrong");

   property p_fast_follows;
      !sleeping && (ctrl_r.sel != SEL_OFF) |=> det_enable && (threshold_select == $past(ctrl_r.sel));
   endproperty
   a_fast_follows: assert property (p_fast_follows) else $error("saving bit acted outside sleep");

   property p_no_set_when_off;
      !det_en_r && !ctrl_r.flag |=> !ctrl_r.flag;
   endproperty
   a_no_set_when_off: assert property (p_no_set_when_off) else $error("flag set while detector off");

   property p_status_sets;
      low_event |=> ist_r[0];
   endproperty
   a_status_sets: assert property (p_status_sets) else $error("status bit not set by low supply");

   property p_stat_w1c;
      wr_done && (paddr == ADDR_INT_STAT) && pwdata[EVT_LOW_BIT] && !low_event |=> !ist_r[0];
   endproperty
   a_stat_w1c: assert property (p_stat_w1c) else $error("status bit not cleared by one");

   property p_irq_high;
      ist_r[0] && imask_r[0] && !wr_done |=> irq;
   endproperty
   a_irq_high: assert property (p_irq_high) else $error("interrupt low with unmasked status");

   property p_irq_masked;
      !imask_r[0] && !(wr_done && (paddr == ADDR_INT_MASK)) |=> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("interrupt high while masked");

   property p_slverr_unmapped;
      acc_start && !mapped |=> pready && pslverr;
   endproperty
   a_slverr_unmapped: assert property (p_slverr_unmapped) else $error("unmapped access not refused");

   property p_slverr_with_ready;
      pslverr |-> pready;
   endproperty
   a_slverr_with_ready: assert property (p_slverr_with_ready) else $error("error shown outside answer");

   property p_unmapped_dropped;
      acc_done && pwrite && pslverr |=> $stable(aux_r) && $stable(imask_r) && $stable(ctrl_r.sel);
   endproperty
   a_unmapped_dropped: assert property (p_unmapped_dropped) else $error("refused write changed a register");

   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held beyond one cycle");
endmodule : uvd_ctrl

// File: dv/uvd_cmp_model.sv
`timescale 1ns/1ps
module uvd_cmp_model (
   input wire logic det_enable, // Comparator enable
   input wire logic [3:0] threshold_select, // Threshold code
   input wire logic [15:0] supply_mv, // Supply in mV
   output logic cmp_below // High when supply below threshold
);
   logic [15:0] thr;
   // Steps are uneven at the bottom of the range
   always_comb begin
      thr = 16'h0A5A + 16'h0096 * (16'(threshold_select) - 16'h0003);
      if (threshold_select == 4'h1) thr = 16'h0960;
      if (threshold_select == 4'h2) thr = 16'h09F6;
      cmp_below = det_enable && (supply_mv < thr);
   end
endmodule : uvd_cmp_model

// File: dv/low_voltage_detect_ctrl_tb.sv
`timescale 1ns/1ps
module low_voltage_detect_ctrl_tb import uvd_pkg::*;;
   logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [APB_AW-1:0] paddr = '0;
   logic [APB_DW-1:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, cmp_below, det_enable, irq, er;
   logic [SEL_W-1:0] threshold_select;
   uvd_mode_t op_mode = UVD_FAST;
   logic [15:0] supply_mv = 16'h1388;
   int num_errors = 0, checked = 0, cyc = 0;
   uvd_ctrl i_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_mode(op_mode),
      .cmp_below(cmp_below), .det_enable(det_enable), .threshold_select(threshold_select), .irq(irq));
   uvd_cmp_model i_cmp (.det_enable(det_enable), .threshold_select(threshold_select), .supply_mv(supply_mv),
      .cmp_below(cmp_below));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb
   task automatic t_reset();
      apb(0, ADDR_DET_CTRL, 0);
      chk(rd, 32'h0);
      apb(0, ADDR_AUX_TWO, 0);
      chk(rd, 32'h06);
      apb(1, 12'h008, 32'hFF);
      chk(er, 32'h1);
   endtask : t_reset
   task automatic t_codes();
      for (int c = 0; c < 16; c++) begin
         apb(1, ADDR_DET_CTRL, c);
         repeat (2) @(posedge clk_sys);
         chk(det_enable, c != 0);
         chk(threshold_select, c);
         apb(0, ADDR_DET_CTRL, 0);
         chk(rd, c);
      end
   endtask : t_codes
   task automatic t_modes();
      logic on;
      apb(1, ADDR_DET_CTRL, 32'h5);
      for (int s = 0; s < 2; s++) begin
         apb(1, ADDR_AUX_TWO, s ? 32'h26 : 32'h06);
         for (int m = 0; m < 5; m++) begin
            op_mode <= uvd_mode_t'(m);
            repeat (3) @(posedge clk_sys);
            on = !(s == 1 && m >= 2);
            chk(det_enable, on);
            chk(threshold_select, on ? 32'h5 : 32'h0);
         end
      end
      op_mode <= UVD_FAST;
      apb(1, ADDR_AUX_TWO, 32'h06);
   endtask : t_modes
   task automatic t_flag();
      apb(1, ADDR_INT_MASK, 32'h1);
      apb(1, ADDR_DET_CTRL, 32'hF);
      supply_mv <= 16'h07D0;
      repeat (6) @(posedge clk_sys);
      supply_mv <= 16'h1388;
      chk(irq, 32'h1);
      apb(0, ADDR_INT_STAT, 0);
      chk(rd, 32'h1);
      apb(1, ADDR_DET_CTRL, 32'h1F);
      apb(0, ADDR_DET_CTRL, 0);
      chk(rd, 32'h1F);
      apb(1, ADDR_DET_CTRL, 32'hF);
      apb(0, ADDR_DET_CTRL, 0);
      chk(rd, 32'hF);
      apb(1, ADDR_INT_MASK, 32'h0);
      chk(irq, 32'h0);
      apb(1, ADDR_INT_MASK, 32'h1);
      apb(1, ADDR_INT_STAT, 32'h1);
      chk(irq, 32'h0);
      apb(1, ADDR_DET_CTRL, 32'h0);
      supply_mv <= 16'h07D0;
      repeat (6) @(posedge clk_sys);
      apb(0, ADDR_DET_CTRL, 0);
      chk(rd, 32'h0);
      chk(irq, 32'h0);
      supply_mv <= 16'h1388;
   endtask : t_flag
   task automatic end_sim();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_sim
   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_reset();
      t_codes();
      t_modes();
      t_flag();
      end_sim();
   end
endmodule : low_voltage_detect_ctrl_tb
